/* File: hdl/mrs_pkg.sv */
package mrs_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned POR_DELAY_MS = 100;
   localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned MCD_TIMEOUT_US = 220;
   localparam int unsigned MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * (CLK_HZ / 1000000);
   localparam int unsigned PIN_LOW_MIN_NS = 10;
   localparam int unsigned PIN_LOW_MIN_CYC = 1;
   // ************************************************************
   // Source bit positions
   // ************************************************************
   localparam int unsigned NSRC = 8;
   localparam int unsigned SRC_POR = 0;
   localparam int unsigned SRC_PFAIL = 1;
   localparam int unsigned SRC_PIN = 2;
   localparam int unsigned SRC_CNV = 3;
   localparam int unsigned SRC_SW = 4;
   localparam int unsigned SRC_CMP = 5;
   localparam int unsigned SRC_MCD = 6;
   localparam int unsigned SRC_WDT = 7;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [2:0] OSC_DIV_LOWEST = 3'h7;
   localparam logic [2:0] WDT_INTERVAL_LONGEST = 3'h7;
   localparam logic [7:0] SRC_EN_RST = 8'hFF;
   typedef enum {MRS_HOLD, MRS_DELAY, MRS_CLKWAIT, MRS_RUN} mrs_state_t;
endpackage

/* File: hdl/mrs_reset_seq.sv */
`timescale 1ns/1ns
// Function
// [RL1] In reset the core is halted, registers take defaults, pins are forced and interrupts and timers are off.
// [RL2] Reset never clears data memory, though the stack pointer is reinitialised.
// [RL3] Every port output latch is all ones during and after reset.
// [RL4] A supply-monitor reset drives the reset pin low until its timeout ends.
// [RL5] On exit the program counter is cleared and the clock selects the slowest internal oscillator.
// [RL6] On exit the watchdog is enabled at its longest interval.
// [RL7] Fetch from address zero begins only once the system clock is stable.
// [RL8] Any of eight sources asserts the system reset.
// [RL9] After power-up reset is held for about 100 ms before the pin is released.
// [RL10] The missing-clock detector resets after its timeout without clock activity.
// [RL11] Any reset pin low of at least 10 ns is a valid reset; the code ignores the pin while it drives the pin low itself.
// [RL12] The reset pin is bidirectional, taking external resets and driving internal ones; the code drives it only for power-on and supply-monitor resets.
// [RL13] Software may disable every source except the supply monitor and the pin, the monitor having its own enable pin; the power-on source is not gated either.
// [RL14] After a power-on reset software may lock the watchdog enabled for good.
// [RL15] Reset asserts asynchronously and releases through a two-stage synchroniser.
// [RL16] The cause of the latest reset is kept across reset and cleared by power-on.
module mrs_reset_seq #(
   parameter int unsigned POR_CYC = mrs_pkg::POR_DELAY_CYC,
   parameter int unsigned MCD_CYC = mrs_pkg::MCD_TIMEOUT_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic por_req,
   input wire logic pfail_req,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   input wire logic conversion_start_input,
   input wire logic sw_reset_req,
   input wire logic cmp_zero,
   input wire logic sysclk_activity,
   input wire logic wdt_expire,
   input wire logic supply_monitor_enable_pin,
   input wire logic [7:0] src_enable,
   input wire logic wdt_lock_req,
   input wire logic clk_stable,
   output logic sys_rst_n,
   output logic core_halt,
   output logic fetch_en,
   output logic [15:0] pc_init,
   output logic [7:0] port_latch,
   output logic int_timer_dis,
   output logic [2:0] osc_div,
   output logic wdt_enable,
   output logic [2:0] wdt_interval,
   output logic wdt_locked,
   output logic [7:0] reset_cause
);
   // ************************************************************
   // Reset synchroniser
   // ************************************************************
   logic [1:0] rsync_r;
   logic rst_s_n;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsync_r <= 2'h0;
      end else begin
         rsync_r <= {rsync_r[0], 1'b1};
      end
   end
   assign rst_s_n = rsync_r[1];

   // ************************************************************
   // Source combination
   // ************************************************************
   logic [7:0] src;
   logic mcd_fire;
   // While the device pulls the pin low itself, a low level there says nothing about an outside
   // reset, so the pin source is masked; an outside pulse inside that time is not seen.
   logic self_drive;
   always_comb begin
      src = 8'h00;
      src[mrs_pkg::SRC_POR] = por_req;
      src[mrs_pkg::SRC_PFAIL] = pfail_req & supply_monitor_enable_pin; // [RL13]
      src[mrs_pkg::SRC_PIN] = ~rst_pin_in & ~self_drive; // [RL11] [RL12]
      src[mrs_pkg::SRC_CNV] = conversion_start_input & src_enable[mrs_pkg::SRC_CNV]; // [RL13]
      src[mrs_pkg::SRC_SW] = sw_reset_req & src_enable[mrs_pkg::SRC_SW];
      src[mrs_pkg::SRC_CMP] = cmp_zero & src_enable[mrs_pkg::SRC_CMP];
      src[mrs_pkg::SRC_MCD] = mcd_fire & src_enable[mrs_pkg::SRC_MCD];
      src[mrs_pkg::SRC_WDT] = wdt_expire & src_enable[mrs_pkg::SRC_WDT] | wdt_expire & wdt_locked;
   end

   // Any source forces the internal reset at once; only the release is clocked.
   logic any_src;
   logic [1:0] asrc_r;
   logic src_rel_n;
   assign any_src = |src; // [RL8]
   always_ff @(posedge core_clk or posedge any_src) begin
      if (any_src) begin
         asrc_r <= 2'h0; // [RL15]
      end else begin
         asrc_r <= {asrc_r[0], 1'b1};
      end
   end
   assign src_rel_n = asrc_r[1];

   // ************************************************************
   // Sequencer state
   // ************************************************************
   typedef struct packed {
      mrs_pkg::mrs_state_t st;
      logic [31:0] cnt;
      logic [31:0] mcd_cnt;
      logic pfail_hold;
      logic por_seen;
      logic locked;
      logic [7:0] cause;
   } mrs_regs_t;
   mrs_regs_t s_r;
   mrs_regs_t s_nxt;

   assign mcd_fire = (s_r.mcd_cnt >= MCD_CYC); // [RL10]

   always_comb begin
      s_nxt = s_r;
      if (sysclk_activity) begin
         s_nxt.mcd_cnt = 32'h0;
      end else if (!mcd_fire) begin
         s_nxt.mcd_cnt = s_r.mcd_cnt + 32'h1; // [RL10]
      end
      if (|src) begin
         s_nxt.cause = src; // [RL16]
         s_nxt.st = mrs_pkg::MRS_HOLD;
         s_nxt.cnt = 32'h0;
         s_nxt.pfail_hold = src[mrs_pkg::SRC_POR] | src[mrs_pkg::SRC_PFAIL];
         if (src[mrs_pkg::SRC_POR]) begin
            s_nxt.locked = 1'b0;
            s_nxt.por_seen = 1'b1;
         end
      end else begin
         case (s_r.st)
            mrs_pkg::MRS_HOLD: begin
               if (src_rel_n) begin
                  s_nxt.st = s_r.pfail_hold ? mrs_pkg::MRS_DELAY : mrs_pkg::MRS_CLKWAIT;
               end
            end
            mrs_pkg::MRS_DELAY: begin
               if (s_r.cnt >= POR_CYC - 1) begin
                  s_nxt.st = mrs_pkg::MRS_CLKWAIT; // [RL9]
                  s_nxt.pfail_hold = 1'b0;
               end else begin
                  s_nxt.cnt = s_r.cnt + 32'h1;
               end
            end
            mrs_pkg::MRS_CLKWAIT: begin
               if (clk_stable) begin
                  s_nxt.st = mrs_pkg::MRS_RUN; // [RL7]
               end
            end
            mrs_pkg::MRS_RUN: begin
               if (wdt_lock_req && s_r.por_seen) begin
                  s_nxt.locked = 1'b1; // [RL14]
               end
            end
            default: s_nxt.st = mrs_pkg::MRS_HOLD;
         endcase
      end
   end

   // Cause and lock live outside the reset they report, so only rst_n clears them, except that a power-on source also clears the lock.
   always_ff @(posedge core_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   logic in_rst;
   assign in_rst = (s_r.st != mrs_pkg::MRS_RUN) | ~src_rel_n;
   assign sys_rst_n = ~in_rst;
   assign core_halt = in_rst; // [RL1]
   assign int_timer_dis = in_rst; // [RL1]
   assign fetch_en = (s_r.st == mrs_pkg::MRS_RUN) & src_rel_n; // [RL7]
   assign pc_init = mrs_pkg::PC_RST; // [RL5]
   assign port_latch = mrs_pkg::PORT_LATCH_RST; // [RL3]
   // Data memory is deliberately not tied to this reset. [RL2]
   assign osc_div = mrs_pkg::OSC_DIV_LOWEST; // [RL5]
   assign wdt_enable = 1'b1; // [RL6]
   assign wdt_interval = mrs_pkg::WDT_INTERVAL_LONGEST; // [RL6]
   assign wdt_locked = s_r.locked;
   assign reset_cause = s_r.cause;
   // Open-drain style: only low is driven. [RL12]
   assign rst_pin_out = 1'b0;
   assign self_drive = s_r.pfail_hold | por_req | (pfail_req & supply_monitor_enable_pin);
   assign rst_pin_oe = self_drive; // [RL4]

   // ************************************************************
   // Checks
   // ************************************************************
   property p_src_halts;
      @(posedge core_clk) disable iff (!rst_s_n) any_src |-> core_halt;
   endproperty
   a_src_halts: assert property (p_src_halts) else $error("source did not halt core"); // [RL8]
   property p_pin_held;
      @(posedge core_clk) disable iff (!rst_s_n)
         (s_r.st == mrs_pkg::MRS_DELAY) |-> rst_pin_oe;
   endproperty
   a_pin_held: assert property (p_pin_held) else $error("pin released during delay"); // [RL4]
   property p_fetch_clk;
      @(posedge core_clk) disable iff (!rst_s_n) fetch_en |-> $past(clk_stable) || $past(fetch_en);
   endproperty
   a_fetch_clk: assert property (p_fetch_clk) else $error("fetch before clock stable"); // [RL7]
   property p_pin_low;
      @(posedge core_clk) disable iff (!rst_s_n)
         !rst_pin_in && !rst_pin_oe |-> ##1 (s_r.cause[mrs_pkg::SRC_PIN] && !fetch_en);
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin low not a reset"); // [RL11]
   property p_mcd;
      @(posedge core_clk) disable iff (!rst_s_n)
         mcd_fire && src_enable[mrs_pkg::SRC_MCD] |-> !sys_rst_n ##1 reset_cause[mrs_pkg::SRC_MCD];
   endproperty
   a_mcd: assert property (p_mcd) else $error("clock timeout missed"); // [RL10]
   property p_lock;
      @(posedge core_clk) disable iff (!rst_s_n)
         wdt_locked && !src[mrs_pkg::SRC_POR] |=> wdt_locked;
   endproperty
   a_lock: assert property (p_lock) else $error("watchdog lock dropped"); // [RL14]
   property p_mon_pin;
      @(posedge core_clk) disable iff (!rst_s_n)
         pfail_req && !supply_monitor_enable_pin && !por_req && !s_r.pfail_hold |-> !rst_pin_oe;
   endproperty
   a_mon_pin: assert property (p_mon_pin) else $error("disabled monitor reset"); // [RL13]
   property p_cause;
      @(posedge core_clk) disable iff (!rst_s_n) any_src |=> reset_cause == $past(src);
   endproperty
   a_cause: assert property (p_cause) else $error("cause not latched"); // [RL16]
endmodule

/* File: verif/mcu_reset_sequencer_tb.sv */
`timescale 1ns/1ns
module mcu_reset_sequencer_tb;
   localparam int unsigned PC = 20;
   localparam int unsigned MC = 8;
   logic core_clk, rst_n, por_req, pfail_req, pull_low, conversion_start_input, sw_reset_req;
   logic cmp_zero, sysclk_activity, wdt_expire, supply_monitor_enable_pin, wdt_lock_req;
   logic clk_stable, rst_pin_in, rst_pin_out, rst_pin_oe, sys_rst_n, core_halt, fetch_en;
   logic int_timer_dis, wdt_enable, wdt_locked;
   logic [15:0] pc_init;
   logic [7:0] src_enable, port_latch, reset_cause;
   logic [2:0] osc_div, wdt_interval;
   int n_fail, cmp_count, n;
   // ********************************
   // Design and far side
   // ********************************
   mrs_reset_seq #(.POR_CYC(PC), .MCD_CYC(MC)) dut (.core_clk, .rst_n, .por_req, .pfail_req,
      .rst_pin_in, .rst_pin_out, .rst_pin_oe, .conversion_start_input, .sw_reset_req,
      .cmp_zero, .sysclk_activity, .wdt_expire, .supply_monitor_enable_pin, .src_enable,
      .wdt_lock_req, .clk_stable, .sys_rst_n, .core_halt, .fetch_en, .pc_init, .port_latch,
      .int_timer_dis, .osc_div, .wdt_enable, .wdt_interval, .wdt_locked, .reset_cause);
   mrs_sup_model sup (.pull_low, .dev_oe(rst_pin_oe), .dev_out(rst_pin_out), .pin(rst_pin_in));
   // ********************************
   // Helpers
   // ********************************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic hit(input int b, input logic v);
      @(negedge core_clk);
      case (b)
         0: por_req = v;
         1: pfail_req = v;
         2: pull_low = v;
         3: conversion_start_input = v;
         4: sw_reset_req = v;
         5: cmp_zero = v;
         6: sysclk_activity = ~v;
         default: wdt_expire = v;
      endcase
   endtask
   // A bounded wait, so that a sequencer stuck in reset shows up as a mismatch.
   task automatic run(input int lim);
      n = 0;
      while (sys_rst_n !== 1'b1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      chk("run", 16'h0001, 16'(sys_rst_n));
   endtask
   task automatic go(input int b, input logic [15:0] rst_exp);
      hit(b, 1'b1);
      #1 chk("rst", rst_exp, 16'(sys_rst_n));
      hit(b, 1'b0);
      run(60);
   endtask
   // ********************************
   // Scenarios
   // ********************************
   task automatic t_por;
      clk_stable = 1'b0;
      hit(0, 1'b1);
      #1 chk("rst", 16'h0000, 16'(sys_rst_n));
      hit(0, 1'b0);
      #1 chk("pin", 16'h0000, 16'(rst_pin_in));
      chk("ctl", 16'h0101, 16'({core_halt, 7'h00, int_timer_dis}));
      chk("fetch", 16'h0000, 16'(fetch_en));
      chk("latch", 16'h00FF, 16'(port_latch));
      n = 0;
      while (rst_pin_oe === 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk("delay", 16'h0001, 16'(n >= PC && n <= PC + 5));
      repeat (5) @(negedge core_clk);
      chk("wait", 16'h0000, 16'(sys_rst_n));
      clk_stable = 1'b1;
      run(8);
      chk("fetch", 16'h0001, 16'(fetch_en));
      chk("pc", 16'h0000, pc_init);
      chk("osc", 16'h0007, 16'(osc_div));
      chk("wdt", 16'h000F, 16'({wdt_enable, wdt_interval}));
      chk("latch", 16'h00FF, 16'(port_latch));
      chk("cause", 16'h0001, 16'(reset_cause));
      $display("por test done");
   endtask
   task automatic t_src;
      for (int b = 2; b < 8; b++) begin
         if (b != 6) begin
            go(b, 16'h0000);
            chk("cause", 16'(8'h01 << b), 16'(reset_cause));
         end
      end
      $display("source test done");
   endtask
   task automatic t_dis;
      src_enable = 8'h07;
      supply_monitor_enable_pin = 1'b0;
      for (int b = 1; b < 8; b++) begin
         if (b != 2 && b != 6) go(b, 16'h0001);
      end
      go(2, 16'h0000);
      supply_monitor_enable_pin = 1'b1;
      hit(1, 1'b1);
      hit(1, 1'b0);
      repeat (PC) @(negedge core_clk);
      chk("oe", 16'h0001, 16'(rst_pin_oe));
      run(60);
      chk("cause", 16'h0002, 16'(reset_cause));
      src_enable = 8'hFF;
      $display("disable test done");
   endtask
   task automatic t_mcd;
      hit(6, 1'b1);
      repeat (MC - 2) @(negedge core_clk);
      hit(6, 1'b0);
      chk("rst", 16'h0001, 16'(sys_rst_n));
      hit(6, 1'b1);
      n = 0;
      while (sys_rst_n === 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      chk("mcd", 16'h0001, 16'(n >= MC - 2 && n <= MC + 3));
      hit(6, 1'b0);
      run(20);
      chk("cause", 16'h0040, 16'(reset_cause));
      $display("clock loss test done");
   endtask
   task automatic t_lock;
      @(negedge core_clk) wdt_lock_req = 1'b1;
      @(negedge core_clk) wdt_lock_req = 1'b0;
      src_enable = 8'h7F;
      go(7, 16'h0000);
      chk("lock", 16'h0001, 16'(wdt_locked));
      src_enable = 8'hFF;
      $display("lock test done");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ********************************
   // Run
   // ********************************
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      #(40 * 4000);
      n_fail++;
      results;
   end
   initial begin
      {rst_n, por_req, pfail_req, pull_low, conversion_start_input, sw_reset_req} = '0;
      {cmp_zero, wdt_expire, wdt_lock_req, n_fail, cmp_count} = '0;
      {sysclk_activity, supply_monitor_enable_pin, clk_stable} = 3'h7;
      src_enable = 8'hFF;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      // The synchronised reset needs two edges before a source can be latched.
      repeat (2) @(negedge core_clk);
      t_por;
      t_src;
      t_dis;
      t_mcd;
      t_lock;
      results;
   end
endmodule

/* File: verif/mrs_sup_model.sv */
`timescale 1ns/1ns
// ********************************
// External supervisor on the pin
// ********************************
module mrs_sup_model (
   input wire logic pull_low,
   input wire logic dev_oe,
   input wire logic dev_out,
   output logic pin
);
   // The line has a pull-up, so it reads high when nobody drives it.
   assign pin = ~pull_low & (dev_oe ? dev_out : 1'b1);
endmodule
